// file: logic/alsr_defines.svh
`ifndef ALSR_DEFINES_SVH
`define ALSR_DEFINES_SVH

// ***********************************
// clock and link timing
// ***********************************
`define ALSR_CLK_MHZ        20
`define ALSR_CNV_HIGH_NS    20
`define ALSR_FIRST_BIT_NS   200
`define ALSR_CNV_HIGH_RAW   (`ALSR_CNV_HIGH_NS * `ALSR_CLK_MHZ / 1000)
`define ALSR_CNV_HIGH_CYC   ((`ALSR_CNV_HIGH_RAW > 0) ? `ALSR_CNV_HIGH_RAW : 1)
`define ALSR_FIRST_BIT_CYC  ((`ALSR_FIRST_BIT_NS * `ALSR_CLK_MHZ + 999) / 1000)
`define ALSR_SCLK_HALF_CYC  2
`define ALSR_SETTLE_CYC     8
`define ALSR_HUNT_CYC       24

// ***********************************
// word framing
// ***********************************
`define ALSR_WORD_BITS      16
`define ALSR_ECHO_PULSES    16
`define ALSR_SELF_PULSES    18
`define ALSR_HDR_SKIP_BITS  1

`endif

// file: logic/alsr_pkg.sv
`include "alsr_defines.svh"

package alsr_pkg;

  // ***********************************
  // sequencer states
  // ***********************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CNV    = 3'b001,
    ST_WAIT   = 3'b011,
    ST_BURST  = 3'b010,
    ST_SETTLE = 3'b110
  } alsr_state_type;

  typedef enum logic [1:0] {
    AL_IDLE  = 2'b00,
    AL_HUNT  = 2'b01,
    AL_SHIFT = 2'b11
  } alsr_align_type;

  // ***********************************
  // result carrier
  // ***********************************
  typedef struct packed {
    logic [`ALSR_WORD_BITS-1:0] code;
    logic                       first;
    logic                       miss;
    logic                       selfMode;
  } alsr_result_type;

endpackage : alsr_pkg

// file: logic/alsr_aligner.sv
`include "alsr_defines.svh"

module alsr_aligner import alsr_pkg::*; #(
  parameter int HALF_CYC  = `ALSR_SCLK_HALF_CYC,
  parameter int WORD_BITS = `ALSR_WORD_BITS,
  parameter int SKIP_BITS = `ALSR_HDR_SKIP_BITS,
  parameter int HUNT_CYC  = `ALSR_HUNT_CYC
) (
  // clock and control
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // stream
  input  wire logic                 arm,
  input  wire logic                 dataIn,
  output logic      [WORD_BITS-1:0] word,
  output logic                      done,
  output logic                      miss
);

  localparam logic [7:0] PERIOD_C = 8'(2 * HALF_CYC);
  localparam logic [7:0] FIRST_C  = 8'(3 * HALF_CYC - 1);
  localparam logic [7:0] HUNT_C   = 8'(HUNT_CYC - 1);
  localparam logic [5:0] LAST_C   = 6'(SKIP_BITS + WORD_BITS - 1);
  localparam logic [5:0] SKIP_C   = 6'(SKIP_BITS);

  alsr_align_type      state_q;
  logic [7:0]          phase_q;
  logic [7:0]          hunt_q;
  logic [5:0]          idx_q;
  logic [WORD_BITS-1:0] word_q;
  logic                done_q;
  logic                miss_q;

  // ***********************************
  // three-phase header search
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= AL_IDLE;
      phase_q <= 8'h00;
      hunt_q  <= 8'h00;
      idx_q   <= 6'h00;
      word_q  <= '0;
      done_q  <= 1'b0;
      miss_q  <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      unique case (state_q)
        AL_IDLE: begin
          if (arm) begin
            state_q <= AL_HUNT;
            hunt_q  <= 8'h00;
          end
        end
        AL_HUNT: begin
          // first logic one marks the header; centre on the bit after it, 1.5 bit periods on
          if (dataIn) begin
            state_q <= AL_SHIFT;
            phase_q <= FIRST_C;
            idx_q   <= 6'h00;
            miss_q  <= 1'b0;
          end else if (hunt_q == HUNT_C) begin
            state_q <= AL_IDLE;
            done_q  <= 1'b1;
            miss_q  <= 1'b1;
          end else begin
            hunt_q <= hunt_q + 8'h01;
          end
        end
        AL_SHIFT: begin
          if (phase_q == 8'h00) begin
            phase_q <= PERIOD_C - 8'h01;
            if (idx_q >= SKIP_C) begin
              word_q <= {word_q[WORD_BITS-2:0], dataIn};
            end
            if (idx_q == LAST_C) begin
              state_q <= AL_IDLE;
              done_q  <= 1'b1;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end else begin
            phase_q <= phase_q - 8'h01;
          end
        end
      endcase
    end
  end

  assign word = word_q;
  assign done = done_q;
  assign miss = miss_q;

endmodule : alsr_aligner

// file: logic/alsr_host.sv
// Operation
// - echoed mode links data, shift clock and echoed clock pairs.
// - host captures data on rising echoed clock edges.
// - host returns the start pulse low within its maximum high time.
// - host bursts shift clock only after the first-bit delay.
// - echoed mode: 16 pulses must finish before the burst deadline.
// - self-clocked mode uses shift clock and data pairs only.
// - host aligns each self-clocked word by finding the header logic one.
// - host starts its alignment machine with its own burst.
// - self-clocked mode: 18 pulses must finish before the deadline.
// - self-clocked mode: shift clock idles high between bursts.
// - selfModePin strap selects self-clocked mode; echoed clock pin is then pulled down.
`include "alsr_defines.svh"

module alsr_host import alsr_pkg::*; #(
  parameter int CNV_HIGH_CYC  = `ALSR_CNV_HIGH_CYC,
  parameter int FIRST_BIT_CYC = `ALSR_FIRST_BIT_CYC,
  parameter int HALF_CYC      = `ALSR_SCLK_HALF_CYC,
  parameter int SETTLE_CYC    = `ALSR_SETTLE_CYC,
  parameter int WORD_BITS     = `ALSR_WORD_BITS
) (
  // clock and control
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  // user side
  input  wire logic            startReq,
  input  wire logic            selfModePin,
  output alsr_result_type      result,
  output logic                 resultValid,
  output logic                 busy,
  // link side
  input  wire logic            echoClk,
  input  wire logic            dataPin,
  output logic                 cnvOut,
  output logic                 sclkOut
);

  localparam logic [7:0] CNV_C    = 8'(CNV_HIGH_CYC);
  localparam logic [7:0] FIRST_C  = 8'(FIRST_BIT_CYC);
  localparam logic [7:0] HALF_C   = 8'(HALF_CYC);
  localparam logic [7:0] SETTLE_C = 8'(SETTLE_CYC);
  localparam logic [7:0] ECHO_E   = 8'(2 * `ALSR_ECHO_PULSES);
  localparam logic [7:0] SELF_E   = 8'(2 * `ALSR_SELF_PULSES);

  alsr_state_type       state_q;
  logic [7:0]           tmr_q;
  logic [7:0]           half_q;
  logic [7:0]           edges_q;
  logic                 mode_q;
  logic                 cnv_q;
  logic                 sclk_q;
  logic                 busy_q;
  logic                 valid_q;
  logic                 firstSeen_q;
  logic                 alnHit_q;
  logic                 alnArm_q;
  alsr_result_type      result_q;
  logic                 modeMeta_q;
  logic                 modeSync_q;
  logic                 dataMeta_q;
  logic                 dataSync_q;
  logic [WORD_BITS-1:0] echoShift_q;
  logic [WORD_BITS-1:0] echoMeta_q;
  logic [WORD_BITS-1:0] echoSync_q;
  logic [WORD_BITS-1:0] alnWord;
  logic                 alnDone;
  logic                 alnMiss;

  // ***********************************
  // pin synchronisers
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      modeMeta_q <= 1'b0;
      modeSync_q <= 1'b0;
      dataMeta_q <= 1'b0;
      dataSync_q <= 1'b0;
    end else if (ce) begin
      modeMeta_q <= selfModePin;
      modeSync_q <= modeMeta_q;
      dataMeta_q <= dataPin;
      dataSync_q <= dataMeta_q;
    end
  end

  // ***********************************
  // echoed clock domain
  // ***********************************
  // no reset: only the last 16 captured bits matter, and the echoed
  // clock stands still outside bursts
  always_ff @(posedge echoClk) begin
    echoShift_q <= {echoShift_q[WORD_BITS-2:0], dataPin};
  end

  // word is quiet once the burst has ended; two stages absorb the
  // last echoed edge before the settle window samples it
  always_ff @(posedge clk) begin
    if (rst) begin
      echoMeta_q <= '0;
      echoSync_q <= '0;
    end else if (ce) begin
      echoMeta_q <= echoShift_q;
      echoSync_q <= echoMeta_q;
    end
  end

  // ***********************************
  // conversion sequencer
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tmr_q   <= 8'h00;
      mode_q  <= 1'b0;
      cnv_q   <= 1'b0;
      busy_q  <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          // no new start until the word is in, so a burst never runs
          // into the next conversion
          if (startReq) begin
            state_q <= ST_CNV;
            tmr_q   <= 8'h01;
            mode_q  <= modeSync_q;
            cnv_q   <= 1'b1;
            busy_q  <= 1'b1;
          end
        end
        ST_CNV: begin
          if (tmr_q >= CNV_C) begin
            cnv_q   <= 1'b0;
            state_q <= ST_WAIT;
          end
          tmr_q <= tmr_q + 8'h01;
        end
        ST_WAIT: begin
          // timer runs from the start edge: burst gated by first-bit delay
          if (tmr_q >= FIRST_C) begin
            state_q <= ST_BURST;
          end
          tmr_q <= tmr_q + 8'h01;
        end
        ST_BURST: begin
          if (half_q == HALF_C - 8'h01 && edges_q == 8'h01) begin
            state_q <= ST_SETTLE;
            tmr_q   <= 8'h00;
          end
        end
        ST_SETTLE: begin
          tmr_q <= tmr_q + 8'h01;
          if (mode_q ? alnHit_q : (tmr_q == SETTLE_C - 8'h01)) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
          cnv_q   <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************
  // shift clock burst
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q  <= 1'b0;
      half_q  <= 8'h00;
      edges_q <= 8'h00;
    end else if (ce) begin
      if (state_q == ST_BURST) begin
        if (half_q == HALF_C - 8'h01) begin
          half_q  <= 8'h00;
          sclk_q  <= ~sclk_q;
          edges_q <= edges_q - 8'h01;
        end else begin
          half_q <= half_q + 8'h01;
        end
      end else begin
        half_q  <= 8'h00;
        edges_q <= mode_q ? SELF_E : ECHO_E;
        if (state_q == ST_IDLE) begin
          sclk_q <= modeSync_q;
        end else begin
          sclk_q <= mode_q;
        end
      end
    end
  end

  // ***********************************
  // self-clocked alignment
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      alnArm_q <= 1'b0;
      alnHit_q <= 1'b0;
    end else if (ce) begin
      alnArm_q <= mode_q && state_q == ST_WAIT && tmr_q >= FIRST_C;
      // aligner may finish before the last edge; keep its news
      if (alnDone) begin
        alnHit_q <= 1'b1;
      end else if (alnArm_q) begin
        alnHit_q <= 1'b0;
      end
    end
  end

  alsr_aligner #(
    .HALF_CYC  (HALF_CYC),
    .WORD_BITS (WORD_BITS),
    .SKIP_BITS (`ALSR_HDR_SKIP_BITS),
    .HUNT_CYC  (`ALSR_HUNT_CYC)
  ) u_aligner (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .arm    (alnArm_q),
    .dataIn (dataSync_q),
    .word   (alnWord),
    .done   (alnDone),
    .miss   (alnMiss)
  );

  // ***********************************
  // result delivery
  // ***********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q    <= '0;
      valid_q     <= 1'b0;
      firstSeen_q <= 1'b0;
    end else if (ce) begin
      valid_q <= 1'b0;
      if (state_q == ST_SETTLE &&
          (mode_q ? alnHit_q : (tmr_q == SETTLE_C - 8'h01))) begin
        valid_q           <= 1'b1;
        firstSeen_q       <= 1'b1;
        result_q.first    <= ~firstSeen_q;
        result_q.selfMode <= mode_q;
        result_q.code     <= mode_q ? alnWord : echoSync_q;
        result_q.miss     <= mode_q & alnMiss;
      end
    end
  end

  assign cnvOut      = cnv_q;
  assign sclkOut     = sclk_q;
  assign busy        = busy_q;
  assign resultValid = valid_q;
  assign result      = result_q;

endmodule : alsr_host

// file: sim/alsr_host_chk.sv
module alsr_host_chk import alsr_pkg::*; (
  // clock and control
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  // user side
  input wire logic            startReq,
  input wire logic            selfModePin,
  input wire alsr_result_type result,
  input wire logic            resultValid,
  input wire logic            busy,
  // link side
  input wire logic            echoClk,
  input wire logic            dataPin,
  input wire logic            cnvOut,
  input wire logic            sclkOut
);
  // ********
  // burst pulse count
  // ********
  logic [5:0] rises_q;
  default clocking cb @(posedge clk); endclocking
  // frozen cycles stretch every figure, so they are skipped
  default disable iff (rst || !ce);
  always_ff @(posedge clk) begin
    if (rst || cnvOut) begin
      rises_q <= 6'h00;
    end else if ($rose(sclkOut)) begin
      rises_q <= rises_q + 6'h01;
    end
  end
  // ********
  // properties
  // ********
  sequence s_start; $rose(cnvOut); endsequence
  // shift clock must stay put through the whole first-bit delay
  sequence s_quiet; $stable(sclkOut) [*6]; endsequence
  property p_cnvHigh; s_start |=> !cnvOut; endproperty
  property p_take; startReq && !busy |=> busy && cnvOut; endproperty
  property p_cause; s_start |-> $past(startReq) && !$past(busy); endproperty
  property p_gate; s_start |-> s_quiet; endproperty
  property p_done; s_start |-> ##[60:160] resultValid; endproperty
  property p_echoLen;
    resultValid && !result.selfMode |-> rises_q == 6'h10;
  endproperty
  property p_selfLen;
    resultValid && result.selfMode |-> rises_q == 6'h12;
  endproperty
  property p_idleLow; resultValid && !result.selfMode |-> !sclkOut; endproperty
  property p_idleHigh; resultValid && result.selfMode |-> sclkOut; endproperty
  a_cnvHigh: assert property (p_cnvHigh)
    else $error("start pulse too long");
  a_take: assert property (p_take)
    else $error("start not taken");
  a_cause: assert property (p_cause)
    else $error("start pulse without request");
  a_gate: assert property (p_gate)
    else $error("shift clock before first-bit delay");
  a_done: assert property (p_done)
    else $error("result late");
  a_echoLen: assert property (p_echoLen)
    else $error("echoed burst length wrong");
  a_selfLen: assert property (p_selfLen)
    else $error("self burst length wrong");
  a_idleLow: assert property (p_idleLow)
    else $error("shift clock not idle low");
  a_idleHigh: assert property (p_idleHigh)
    else $error("shift clock not idle high");
endmodule : alsr_host_chk

bind alsr_host alsr_host_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
  .startReq(startReq), .selfModePin(selfModePin), .result(result),
  .resultValid(resultValid), .busy(busy), .echoClk(echoClk),
  .dataPin(dataPin), .cnvOut(cnvOut), .sclkOut(sclkOut));

// file: sim/alsr_conv_model.sv
module alsr_conv_model #(
  parameter int TMSB_NS = 150
) (
  // from host
  input  wire logic        cnv,
  input  wire logic        sclk,
  // strap and bench
  input  wire logic        selfMode,
  input  wire logic        mute,
  input  wire logic [15:0] code,
  // to host
  output logic             echoClk,
  output logic             data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // converter
  // ********
  logic [17:0] sr = 18'h00000;
  logic        conv = 1'b0;
  logic        powered = 1'b0;
  initial data = 1'b0;
  task automatic shift;
    sr = sr << 1;
    data = sr[17] & !mute;
  endtask : shift
  // pin pulled down in self-clocked mode
  assign #2 echoClk = selfMode ? 1'b0 : sclk;
  always @(posedge cnv) begin
    if (!conv) begin
      conv = 1'b1;
      // first word after power-up is junk on purpose
      sr = {2'b10, powered ? code : ~code};
      if (!selfMode) sr = sr << 2;
      powered = 1'b1;
      data = 1'b0;
      #(TMSB_NS);
      data = sr[17] & !mute;
      conv = 1'b0;
    end
  end
  always @(negedge echoClk) if (!selfMode) shift();
  always @(negedge sclk) if (selfMode) shift();
endmodule : alsr_conv_model

// file: sim/alsr_host_tb.sv
module alsr_host_tb import alsr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
  logic            clk, rst, ce, startReq, selfModePin, mute;
  logic [15:0]     nextCode;
  alsr_result_type result, got;
  logic            resultValid, busy, echoClk, dataPin, cnvOut, sclkOut;
  int              failures = 0;
  int              total_checks = 0;
  int              cnvRises = 0;
  alsr_host dut (.clk(clk), .rst(rst), .ce(ce), .startReq(startReq),
    .selfModePin(selfModePin), .result(result), .resultValid(resultValid),
    .busy(busy), .echoClk(echoClk), .dataPin(dataPin), .cnvOut(cnvOut),
    .sclkOut(sclkOut));
  alsr_conv_model conv (.cnv(cnvOut), .sclk(sclkOut), .selfMode(selfModePin),
    .mute(mute), .code(nextCode), .echoClk(echoClk), .data(dataPin));
  always @(posedge cnvOut) cnvRises++;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ********
  // shared tasks
  // ********
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // one conversion; a second request is poked in mid-burst
  task automatic run_conv(input logic [15:0] c, input int stall,
                          output alsr_result_type r);
    int n;
    cnvRises = 0;
    @(posedge clk);
    nextCode <= c;
    startReq <= 1'b1;
    @(posedge clk);
    startReq <= 1'b0;
    repeat (12) @(posedge clk);
    startReq <= 1'b1;
    ce <= (stall == 0);
    repeat (stall + 1) @(posedge clk);
    startReq <= 1'b0;
    ce <= 1'b1;
    n = 0;
    while (resultValid !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        failures++;
        end_sim();
      end
    end
    r = result;
    `CHK(cnvRises, 1)
    `CHK(sclkOut, selfModePin)
  endtask : run_conv
  // ********
  // scenarios
  // ********
  task automatic t_first;
    run_conv(16'h1234, 0, got);
    `CHK(got.first, 1'b1)
    `CHK(got.selfMode, 1'b0)
  endtask : t_first
  task automatic t_echo;
    run_conv(16'h8001, 0, got);
    `CHK(got, {16'h8001, 3'b000})
    run_conv(16'h7FFE, 6, got);
    `CHK(got, {16'h7FFE, 3'b000})
  endtask : t_echo
  task automatic t_self;
    @(posedge clk);
    selfModePin <= 1'b1;
    repeat (6) @(posedge clk);
    run_conv(16'hA5C3, 0, got);
    `CHK(got, {16'hA5C3, 3'b001})
    run_conv(16'h0001, 0, got);
    `CHK(got, {16'h0001, 3'b001})
  endtask : t_self
  task automatic t_miss;
    @(posedge clk);
    mute <= 1'b1;
    run_conv(16'h5555, 0, got);
    `CHK(got.miss, 1'b1)
    @(posedge clk);
    mute <= 1'b0;
  endtask : t_miss
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    startReq = 1'b0;
    selfModePin = 1'b0;
    mute = 1'b0;
    nextCode = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_first();
    t_echo();
    t_self();
    t_miss();
    end_sim();
  end
endmodule : alsr_host_tb
